// ===== design/trmux_map.svh
// Register offsets, field positions, reset values and counts of the receive bus multiplexer.
`ifndef TRMUX_MAP_SVH
`define TRMUX_MAP_SVH
`define TRMUX_FRAMERS 8
`define TRMUX_REG_STATUS 5'h10
`define TRMUX_CLK_EDGE_B 0
`define TRMUX_FP_EDGE_B 1
`define TRMUX_TRI_LO 4
`define TRMUX_TRI_HI 5
`define TRMUX_BOC_B 6
`define TRMUX_BSEL_B 7
`define TRMUX_PAR_EN_B 8
`define TRMUX_PAR_TYP_B 9
`define TRMUX_PAR_EXT_B 10
`define TRMUX_CMS_B 11
`define TRMUX_DRE_B 12
`define TRMUX_FRAME_PULSE_INVERT_B 13
`define TRMUX_BIT_OFFSET_ENABLE_B 14
`define TRMUX_CHOFF_LO 0
`define TRMUX_CHOFF_HI 6
`define TRMUX_BOFF_LO 8
`define TRMUX_BOFF_HI 10
`define TRMUX_CFG_MASK 16'h7ff3
`define TRMUX_OFF_MASK 16'h077f
`define TRMUX_CFG_RST 16'h0000
`define TRMUX_OFF_RST 16'h0000
`define TRMUX_LAST_TS 5'h18
`define TRMUX_EDGES_SAME 5'h02
`define TRMUX_EDGES_DIFF 5'h01
`endif

// ===== design/trmux_pkg.sv
// Types shared by the receive bus multiplexer.
package trmux_pkg;
	typedef enum logic [2:0]
	{
		TRMUX_HUNT = 3'h1,
		TRMUX_DELAY = 3'h2,
		TRMUX_RUN = 3'h4
	} trmux_state_e;
	typedef logic [4:0] trmux_edges_t;
endpackage

// ===== design/trmux_edge.sv
// Synchroniser and edge finder for the shared bus clock and frame pulse.
`timescale 1ns/100ps
module trmux_edge
(
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic ck_pin, // Shared bus clock pin.
	input wire logic fp_pin, // Shared frame pulse pin.
	output logic rise, // Bus clock rose.
	output logic fall, // Bus clock fell.
	output logic fp_lvl // Synchronised frame pulse level.
);
	logic [2:0] ck_q;
	logic [1:0] fp_q;

	// Both pins pass the same two stages so their relative timing survives.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ck_q <= 3'h0;
			fp_q <= 2'h0;
		end
		else
		begin
			ck_q <= {ck_q[1:0], ck_pin};
			fp_q <= {fp_q[0], fp_pin};
		end
	end

	assign rise = ck_q[1] & ~ck_q[2];
	assign fall = ~ck_q[1] & ck_q[2];
	assign fp_lvl = fp_q[1];
endmodule

// ===== design/trmux_slot.sv
// One framer's slot on a shared bus: timeslot decode, bit pick and F-bit parity.
`timescale 1ns/100ps
`include "trmux_map.svh"
module trmux_slot
(
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic tick, // Bus advances to pos_nx.
	input wire logic [9:0] pos_nx, // Bus bit about to be driven.
	input wire logic [6:0] choff, // Channel offset.
	input wire logic par_en, // Parity into F-bit.
	input wire logic par_typ, // 1 odd, 0 even.
	input wire logic par_ext, // F-bit counted in parity.
	input wire logic fbit, // F-bit from the framer.
	input wire logic [7:0] data_byte, // Channel byte from the framer.
	input wire logic [3:0] sig, // Signalling nibble of the channel.
	output logic mine, // Slot owns pos_nx.
	output logic is_f, // pos_nx is the F-bit.
	output logic [4:0] ts, // Framer timeslot at pos_nx.
	output logic dbit, // Data bit for pos_nx.
	output logic sbit // Signalling bit for pos_nx.
);
	logic [6:0] rel;
	logic [2:0] bi;
	logic acc_q, acc_d, fval;

	function automatic logic pick(input logic [7:0] v, input logic [2:0] i);
		pick = v[3'h7 - i];
	endfunction

	// Four framers interleave byte by byte, so a slot owns every fourth channel.
	assign rel = pos_nx[9:3] - choff;
	assign ts = rel[6:2];
	assign bi = pos_nx[2:0];
	assign mine = (rel[1:0] == 2'h0) && (ts <= `TRMUX_LAST_TS);
	assign is_f = (ts == 5'h00) && (bi == 3'h0);
	assign fval = par_en ? (acc_q ^ par_typ) : fbit;
	assign dbit = is_f ? fval : ((ts == 5'h00) ? 1'b0 : pick(data_byte, bi));
	assign sbit = is_f ? fval : ((ts == 5'h00) ? 1'b0 : pick({4'h0, sig}, bi));
	assign acc_d = is_f ? (par_ext & fval) : (acc_q ^ dbit);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			acc_q <= 1'b0;
		else if (tick && mine)
			acc_q <= acc_d;
	end

	property p_par_restart;
		@(posedge clk) disable iff (!rst_n)
		(tick && mine && is_f && !par_ext) |=> (acc_q == 1'b0);
	endproperty
	a_par_restart: assert property (p_par_restart) else $error("parity restart wrong");
endmodule

// ===== design/trmux_rx_mux.sv
// Receive multiplexed-bus output logic for eight T1 framers on two shared buses.
// How it works
// - frame pulse and outputs use their selected edges
// - any framer's edge bit set applies to all
// - double rate, equal edge kinds: update first edge
// - one shared bus clock, single or double rate
// - double rate: chosen update edge, pulse first edge
// - any rate or edge-select bit set applies to all
// - each bus carries 1024 bits per frame
// - bus frame pulse marks first framer's F-bits
// - signalling output aligned with its channel data
// - channel bit 1 leaves first
// - parity of previous frame replaces F-bit
// - parity type and F-bit inclusion selectable
// - channel offset delays each framer's frame start
// - bit offset off at double rate
// - bit offset counts 2*code+1 or +2 edges
// - pulse and signalling share data's timing
// - tri field drives or floats the framer
// - up to four framers interleave per bus
// - output control bit gates framer onto bus
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "trmux_map.svh"
module trmux_rx_mux
(
	input wire logic CORE_CLK, // Core clock, 25 MHz.
	input wire logic RST_N, // Synchronous reset, active low.
	input wire logic MUX_BUS_COMMON_CLOCK, // Shared bus clock pin.
	input wire logic MUX_BUS_COMMON_FRAME_PULSE, // Shared frame pulse pin.
	input wire logic [63:0] FRAMER_DATA, // Byte per framer for its requested slot.
	input wire logic [31:0] FRAMER_SIG, // Signalling nibble per framer.
	input wire logic [7:0] FRAMER_FBIT, // F-bit per framer.
	output logic [39:0] FRAMER_TS_REQ, // Timeslot requested per framer.
	output logic [1:0] MUX_BUS_DATA_OUT, // Bus data, one per bus.
	output logic [1:0] MUX_BUS_DATA_OUT_OE, // Bus data drive enable.
	output logic [1:0] MUX_BUS_SIGNALLING_OUT, // Bus signalling.
	output logic [1:0] MUX_BUS_SIGNALLING_OUT_OE, // Bus signalling drive enable.
	output logic [1:0] MUX_BUS_FRAME_PULSE_OUT, // Bus frame pulse.
	input wire logic [4:0] REG_ADDR, // Register address.
	input wire logic [15:0] REG_WDATA, // Register write data.
	input wire logic REG_WR, // Write strobe.
	input wire logic REG_RD, // Read strobe.
	output logic [15:0] REG_RDATA // Read data, cycle after the strobe.
);
	logic [15:0] cfg_q [`TRMUX_FRAMERS];
	logic [15:0] off_q [`TRMUX_FRAMERS];
	logic [15:0] rdata_d, rdata_q, sel_word, status;
	logic ck_rise_e, ck_fall_e, fp_lvl;
	logic [7:0] v_ck, v_fp, v_cms, v_dre, v_inv, v_boc, v_bsel;
	logic [7:0] v_mine, v_isf, v_dbit, v_sbit, v_en, en0, en1, first0, first1;
	logic ck_rise, fp_fall, clock_rate_sel, dre, frame_pulse_invert, same_type, boff_on;
	logic upd_edge, smp_edge, fp_act, pulse_now, ph_eff, tick, fstart, drive;
	logic ph_q, ph_d, fp_prev_q, aligned_q;
	trmux_pkg::trmux_state_e state_q, state_d;
	trmux_pkg::trmux_edges_t dly_q, dly_d, n_edges;
	logic [9:0] pos_q, pos_nx;
	logic [1:0] dout_d, dout_q, doe_d, doe_q, sout_d, sout_q, soe_d, soe_q, fpo_d, fpo_q;

	// Picks the lowest set bit; the first framer of a bus owns its frame pulse.
	function automatic logic [7:0] lowest(input logic [7:0] v);
		lowest = v & (~v + 8'h01);
	endfunction

	trmux_edge u_edge
	(
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.ck_pin(MUX_BUS_COMMON_CLOCK),
		.fp_pin(MUX_BUS_COMMON_FRAME_PULSE),
		.rise(ck_rise_e),
		.fall(ck_fall_e),
		.fp_lvl(fp_lvl)
	);

	genvar gi;
	generate
		for (gi = 0; gi < `TRMUX_FRAMERS; gi++)
		begin : g_fr
			assign v_ck[gi] = cfg_q[gi][`TRMUX_CLK_EDGE_B];
			assign v_fp[gi] = cfg_q[gi][`TRMUX_FP_EDGE_B];
			assign v_cms[gi] = cfg_q[gi][`TRMUX_CMS_B];
			assign v_dre[gi] = cfg_q[gi][`TRMUX_DRE_B];
			assign v_inv[gi] = cfg_q[gi][`TRMUX_FRAME_PULSE_INVERT_B];
			assign v_boc[gi] = cfg_q[gi][`TRMUX_BOC_B];
			assign v_bsel[gi] = cfg_q[gi][`TRMUX_BSEL_B];
			assign v_en[gi] = drive & v_mine[gi] & v_boc[gi]
				& (|cfg_q[gi][`TRMUX_TRI_HI:`TRMUX_TRI_LO]);
			trmux_slot u_slot
			(
				.clk(CORE_CLK),
				.rst_n(RST_N),
				.tick(tick),
				.pos_nx(pos_nx),
				.choff(off_q[gi][`TRMUX_CHOFF_HI:`TRMUX_CHOFF_LO]),
				.par_en(cfg_q[gi][`TRMUX_PAR_EN_B]),
				.par_typ(cfg_q[gi][`TRMUX_PAR_TYP_B]),
				.par_ext(cfg_q[gi][`TRMUX_PAR_EXT_B]),
				.fbit(FRAMER_FBIT[gi]),
				.data_byte(FRAMER_DATA[gi*8 +: 8]),
				.sig(FRAMER_SIG[gi*4 +: 4]),
				.mine(v_mine[gi]),
				.is_f(v_isf[gi]),
				.ts(FRAMER_TS_REQ[gi*5 +: 5]),
				.dbit(v_dbit[gi]),
				.sbit(v_sbit[gi])
			);
		end
	endgenerate

	// Settings that must agree across framers, other than the bit offset read from framer 0, are combined as a wired OR.
	assign ck_rise = |v_ck;
	assign fp_fall = |v_fp;
	assign clock_rate_sel = |v_cms;
	assign dre = |v_dre;
	assign frame_pulse_invert = |v_inv;

	assign same_type = fp_fall ^ ck_rise;
	assign upd_edge = ck_rise ? ck_rise_e : ck_fall_e;
	assign smp_edge = fp_fall ? ck_fall_e : ck_rise_e;
	assign fp_act = fp_lvl ^ frame_pulse_invert;
	// Only the first sampling edge of a held pulse counts, which at double rate is the first edge.
	assign pulse_now = smp_edge & fp_act & ~fp_prev_q;
	assign ph_eff = (pulse_now & same_type) ? 1'b0 : ph_q;
	assign tick = upd_edge & (~clock_rate_sel | (ph_eff == (same_type ? 1'b0 : dre)));

	assign boff_on = cfg_q[0][`TRMUX_BIT_OFFSET_ENABLE_B] & ~clock_rate_sel;
	assign n_edges = {1'b0, off_q[0][`TRMUX_BOFF_HI:`TRMUX_BOFF_LO], 1'b0}
		+ (same_type ? `TRMUX_EDGES_SAME : `TRMUX_EDGES_DIFF);
	assign fstart = tick & (state_q == trmux_pkg::TRMUX_DELAY) & (dly_q == 5'h00) & ~pulse_now;
	assign pos_nx = fstart ? 10'h000 : (pos_q + 10'h001);
	assign drive = fstart | aligned_q;

	assign en0 = v_en & ~v_bsel;
	assign en1 = v_en & v_bsel;
	assign first0 = lowest(v_boc & ~v_bsel);
	assign first1 = lowest(v_boc & v_bsel);
	assign dout_d = {|(en1 & v_dbit), |(en0 & v_dbit)};
	assign doe_d = {|en1, |en0};
	assign sout_d = {|(en1 & v_sbit), |(en0 & v_sbit)};
	assign soe_d = {|en1, |en0};
	assign fpo_d = {drive & (|(first1 & v_isf & v_mine)),
		drive & (|(first0 & v_isf & v_mine))} ^ {frame_pulse_invert, frame_pulse_invert};

	always_comb
	begin
		state_d = state_q;
		dly_d = dly_q;
		ph_d = ph_q;
		if (pulse_now)
		begin
			state_d = trmux_pkg::TRMUX_DELAY;
			dly_d = boff_on ? n_edges : 5'h00;
			ph_d = same_type;
		end
		else
		begin
			if (fstart)
				state_d = trmux_pkg::TRMUX_RUN;
			if (upd_edge)
				ph_d = ~ph_q;
			if ((state_q == trmux_pkg::TRMUX_DELAY) && (ck_rise_e | ck_fall_e) && (dly_q != 5'h00))
				dly_d = dly_q - 5'h01;
		end
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			state_q <= trmux_pkg::TRMUX_HUNT;
			dly_q <= 5'h00;
			ph_q <= 1'b0;
			fp_prev_q <= 1'b0;
			aligned_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			dly_q <= dly_d;
			ph_q <= ph_d;
			if (smp_edge)
				fp_prev_q <= fp_act;
			if (fstart)
				aligned_q <= 1'b1;
		end
	end

	// All bus outputs move together on the update tick, keeping them aligned.
	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			pos_q <= 10'h000;
			dout_q <= 2'h0;
			doe_q <= 2'h0;
			sout_q <= 2'h0;
			soe_q <= 2'h0;
			fpo_q <= 2'h0;
		end
		else if (tick)
		begin
			pos_q <= pos_nx;
			dout_q <= dout_d;
			doe_q <= doe_d;
			sout_q <= sout_d;
			soe_q <= soe_d;
			fpo_q <= fpo_d;
		end
	end

	assign MUX_BUS_DATA_OUT = dout_q;
	assign MUX_BUS_DATA_OUT_OE = doe_q;
	assign MUX_BUS_SIGNALLING_OUT = sout_q;
	assign MUX_BUS_SIGNALLING_OUT_OE = soe_q;
	assign MUX_BUS_FRAME_PULSE_OUT = fpo_q;

	// Register file: framer n config at 2n, offsets at 2n+1, status above.
	assign sel_word = REG_ADDR[0] ? off_q[REG_ADDR[3:1]] : cfg_q[REG_ADDR[3:1]];
	assign status = {2'h0, aligned_q, state_q, pos_q};
	assign rdata_d = !REG_RD ? 16'h0000 : (!REG_ADDR[4] ? sel_word
		: ((REG_ADDR == `TRMUX_REG_STATUS) ? status : 16'h0000));

	always_ff @(posedge CORE_CLK)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < `TRMUX_FRAMERS; i++)
			begin
				cfg_q[i] <= `TRMUX_CFG_RST;
				off_q[i] <= `TRMUX_OFF_RST;
			end
			rdata_q <= 16'h0000;
		end
		else
		begin
			rdata_q <= rdata_d;
			if (REG_WR && !REG_ADDR[4] && REG_ADDR[0])
				off_q[REG_ADDR[3:1]] <= REG_WDATA & `TRMUX_OFF_MASK;
			if (REG_WR && !REG_ADDR[4] && !REG_ADDR[0])
				cfg_q[REG_ADDR[3:1]] <= REG_WDATA & `TRMUX_CFG_MASK;
		end
	end

	assign REG_RDATA = rdata_q;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	property p_hold_between;
		!tick |=> ($stable(dout_q) && $stable(fpo_q) && $stable(sout_q));
	endproperty
	a_hold_between: assert property (p_hold_between) else $error("outputs moved off tick");

	property p_rise_only;
		(ck_rise && ck_fall_e) |-> !tick;
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("tick on wrong clock edge");

	property p_same_first;
		(clock_rate_sel && same_type && tick) |-> (ph_eff == 1'b0);
	endproperty
	a_same_first: assert property (p_same_first) else $error("update not on first edge");

	property p_dre_pick;
		(clock_rate_sel && !same_type && tick) |-> (ph_eff == dre);
	endproperty
	a_dre_pick: assert property (p_dre_pick) else $error("update on wrong half bit");

	property p_no_boff;
		(clock_rate_sel && pulse_now) |=> (dly_q == 5'h00);
	endproperty
	a_no_boff: assert property (p_no_boff) else $error("bit offset at double rate");

	property p_boff_load;
		(!clock_rate_sel && cfg_q[0][`TRMUX_BIT_OFFSET_ENABLE_B] && pulse_now) |=> (dly_q == $past(n_edges));
	endproperty
	a_boff_load: assert property (p_boff_load) else $error("bit offset count wrong");

	property p_restart;
		fstart |=> (pos_q == 10'h000) ##0 (state_q == trmux_pkg::TRMUX_RUN);
	endproperty
	a_restart: assert property (p_restart) else $error("frame did not restart");

	property p_step;
		(tick && !fstart) |=> (pos_q == ($past(pos_q) + 10'h001));
	endproperty
	a_step: assert property (p_step) else $error("bit position skipped");

	property p_float;
		(tick && (en0 == 8'h00)) |=> !doe_q[0] && !soe_q[0];
	endproperty
	a_float: assert property (p_float) else $error("bus 0 driven without owner");

	property p_fp_idle;
		(tick && !(|(first0 & v_isf & v_mine))) |=> (fpo_q[0] == $past(frame_pulse_invert));
	endproperty
	a_fp_idle: assert property (p_fp_idle) else $error("frame pulse off F-bit");

	c_fstart: cover property (fstart);
	c_double: cover property (clock_rate_sel && tick && pulse_now);
	c_fp_out: cover property (tick ##1 (fpo_q[0] != frame_pulse_invert));
	c_boff: cover property (boff_on && pulse_now ##[1:40] fstart);
endmodule

// ===== sim/trmux_backplane.sv
// Backplane model that makes the shared bus clock and the shared frame pulse.
`timescale 1ns/100ps
module trmux_backplane
(
	input wire logic inv, // Frame pulse active low.
	output logic ck, // Shared bus clock.
	output logic fp // Shared frame pulse.
);
	int bitc = 0;
	// The 7 ns phase keeps bus edges away from core clock edges.
	initial
	begin
		ck = 1'b0;
		fp = inv;
		#7;
		forever
		begin
			#160 ck = 1'b1;
			#160 ck = 1'b0;
			bitc = (bitc == 1023) ? 0 : bitc + 1;
			fp = (bitc == 0) ^ inv;
		end
	end
endmodule

// ===== sim/trmux_rx_mux_test.sv
// Self-checking bench of the receive bus multiplexer.
`timescale 1ns/100ps
`include "trmux_map.svh"
module trmux_rx_mux_test;
	localparam logic [15:0] CA [8] = '{16'h0350, 16'h00c0, 16'h0060, 16'h00c0,
		16'h0170, 16'h0081, 16'h0010, 16'h0090};
	localparam logic [15:0] OA [8] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001,
		16'h0002, 16'h0002, 16'h0003, 16'h0003};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wd = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic [63:0] fdat = 64'h0;
	logic [31:0] fsig = 32'h0;
	logic [7:0] fbit = 8'h5a;
	logic [39:0] tsq;
	logic [1:0] bd, bdoe, bs, bsoe, bfp;
	logic mck, mfp;
	logic inv = 1'b0;
	logic chk = 1'b0;
	logic [15:0] cfg [8];
	logic [15:0] off [8];
	int error_cnt = 0;
	int n_tests = 0;
	int k = 0;
	int lag = 0;
	int lag_exp = 2;
	int lag1;
	initial
	begin
		forever #20 clk = ~clk;
	end
	trmux_rx_mux i_dut
	(
		.CORE_CLK(clk),
		.RST_N(rst_n),
		.MUX_BUS_COMMON_CLOCK(mck),
		.MUX_BUS_COMMON_FRAME_PULSE(mfp),
		.FRAMER_DATA(fdat),
		.FRAMER_SIG(fsig),
		.FRAMER_FBIT(fbit),
		.FRAMER_TS_REQ(tsq),
		.MUX_BUS_DATA_OUT(bd),
		.MUX_BUS_DATA_OUT_OE(bdoe),
		.MUX_BUS_SIGNALLING_OUT(bs),
		.MUX_BUS_SIGNALLING_OUT_OE(bsoe),
		.MUX_BUS_FRAME_PULSE_OUT(bfp),
		.REG_ADDR(addr),
		.REG_WDATA(wd),
		.REG_WR(wr),
		.REG_RD(rd),
		.REG_RDATA(rdata)
	);
	trmux_backplane i_bp
	(
		.inv(inv),
		.ck(mck),
		.fp(mfp)
	);
	function automatic logic [7:0] fb(int n, logic [4:0] ts);
		return {ts, n[2:0]} ^ 8'h96;
	endfunction
	function automatic logic [3:0] sf(int n, logic [4:0] ts);
		return ts[3:0] ^ {1'b1, n[2:0]};
	endfunction
	// The request is stable for eight core cycles, so one cycle of lag is harmless.
	always @(posedge clk)
	begin
		for (int n = 0; n < 8; n++)
		begin
			fdat[8*n+:8] <= fb(n, tsq[5*n+:5]);
			fsig[4*n+:4] <= sf(n, tsq[5*n+:5]);
		end
	end
	task automatic stop_test();
		if (error_cnt == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp_w(string nm, logic [15:0] e, logic [15:0] s);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmp_b(string nm, int bu, logic e, logic s);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("unexpected %s%0d expected %b seen %b", nm, bu, e, s);
		end
	endtask
	task automatic reg_wr(logic [4:0] a, logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(logic [4:0] a, logic [15:0] e, logic [15:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp_w("read data", e, rdata & m);
	endtask
	task automatic set_fr(int n, logic [15:0] c, logic [15:0] o);
		cfg[n] = c;
		off[n] = o;
		reg_wr(5'(2 * n), c);
		reg_wr(5'(2 * n + 1), o);
		inv = 1'b0;
		for (int i = 0; i < 8; i++)
			inv |= cfg[i][`TRMUX_FRAME_PULSE_INVERT_B];
	endtask
	task automatic frames(int n);
		repeat (n) @(posedge mck iff (mfp ^ inv));
	endtask
	function automatic logic fx(int n);
		logic p;
		if (!cfg[n][`TRMUX_PAR_EN_B])
			return fbit[n];
		p = cfg[n][`TRMUX_PAR_TYP_B];
		for (int t = 1; t < 25; t++)
			p ^= ^fb(n, 5'(t));
		return p;
	endfunction
	task automatic chk_bus(int bu, int pos);
		int c, b, r, fst, tq;
		logic [7:0] by;
		logic [3:0] sn;
		logic oe, d, s, f, sc;
		fst = 8;
		{oe, d, s, f, sc} = 5'h00;
		c = pos >> 3;
		b = pos % 8;
		for (int n = 7; n >= 0; n--)
			if (cfg[n][`TRMUX_BSEL_B] == bu && cfg[n][`TRMUX_BOC_B])
				fst = n;
		for (int n = 0; n < 8; n++)
		begin
			r = c - int'(off[n][6:0]);
			by = fb(n, 5'(r / 4));
			sn = sf(n, 5'(r / 4));
			if (cfg[n][`TRMUX_BSEL_B] == bu && cfg[n][`TRMUX_BOC_B] && r >= 0 && r % 4 == 0
				&& r < 100)
			begin
				f |= (n == fst && r == 0 && b == 0);
				if (cfg[n][`TRMUX_TRI_HI:`TRMUX_TRI_LO] != 2'b00)
				begin
					oe = 1'b1;
					d = (r == 0) ? (b == 0) && fx(n) : by[7 - b];
					s = (r == 0) ? d : sn[(7 - b) % 4];
					sc = (r == 0) ? (b == 0) && cfg[n][`TRMUX_PAR_EN_B] : b >= 4;
				end
			end
		end
		// The request looks one bus bit ahead of what the bus shows now.
		tq = ((((pos + 1) >> 3) - int'(off[0][6:0])) & 127) >> 2;
		if (bu == 0 && pos < 1023)
			cmp_w("timeslot request", 16'(tq), {11'h000, tsq[4:0]});
		cmp_b("data oe", bu, oe, bdoe[bu]);
		cmp_b("sig oe", bu, oe, bsoe[bu]);
		cmp_b("frame pulse", bu, f ^ inv, bfp[bu]);
		if (oe)
			cmp_b("data", bu, d, bd[bu]);
		if (sc)
			cmp_b("sig", bu, s, bs[bu]);
	endtask
	// Outputs of a bit are settled a whole bus period later, so sample on the next edge.
	always @(posedge mck)
	begin
		if (mfp ^ inv)
			k = 0;
		else
			k++;
		if (bfp[0] === ~inv)
			lag = k;
		if (chk && k >= lag_exp)
			for (int bu = 0; bu < 2; bu++)
				chk_bus(bu, k - lag_exp);
	end
	initial
	begin
		#(40 * 90000);
		error_cnt++;
		stop_test();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(5'h00, 16'h0000, 16'hffff);
		reg_rd(`TRMUX_REG_STATUS, 16'h0400, 16'hffff);
		reg_wr(5'h02, 16'hffff);
		reg_wr(5'h03, 16'hffff);
		reg_wr(5'h11, 16'hffff);
		reg_rd(5'h02, `TRMUX_CFG_MASK, 16'hffff);
		reg_rd(5'h03, `TRMUX_OFF_MASK, 16'hffff);
		reg_rd(5'h11, 16'h0000, 16'hffff);
		for (int n = 0; n < 8; n++)
			set_fr(n, CA[n], OA[n]);
		frames(2);
		chk = 1'b1;
		frames(1);
		chk = 1'b0;
		cmp_w("frame lag", 16'h0002, 16'(lag));
		reg_rd(`TRMUX_REG_STATUS, 16'h3000, 16'h3c00);
		set_fr(1, 16'h00d0, 16'h0000);
		set_fr(3, 16'h00d0, 16'h0001);
		set_fr(7, 16'h2090, 16'h0003);
		set_fr(0, 16'h4350, 16'h0100);
		frames(2);
		lag1 = lag;
		lag_exp = lag;
		chk = 1'b1;
		frames(1);
		chk = 1'b0;
		set_fr(0, 16'h4350, 16'h0300);
		frames(2);
		cmp_w("bit offset lag", 16'h0002, 16'(lag - lag1));
		stop_test();
	end
endmodule
